// file: rtl/sbf_pkg.sv
// Shared constants and types for the shared byte buffer
package sbf_pkg;
	// ****************************************
	// Widths and sizes
	// ****************************************
	localparam int          ADDR_W      = 7;
	localparam int          BUF_DEPTH   = 512;
	localparam int          CNT_W       = 10;
	localparam logic [9:0]  CAP_FULL    = 10'h200;
	localparam logic [9:0]  CAP_LIMIT   = 10'h0ff;
	localparam logic [9:0]  READY_SLACK = 10'h001;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [6:0]  OFF_CTRL     = 7'h02;
	localparam logic [6:0]  OFF_THR_LO   = 7'h03;
	localparam logic [6:0]  OFF_FILL     = 7'h04;
	localparam logic [6:0]  OFF_DATA     = 7'h05;
	localparam logic [6:0]  OFF_IRQ_STAT = 7'h06;
	localparam logic [6:0]  OFF_IRQ_EN   = 7'h08;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_FILL_LO = 0;
	localparam int CTRL_FILL_HI = 1;
	localparam int CTRL_THR_MSB = 2;
	localparam int CTRL_SIZE    = 3;
	localparam int CTRL_FLUSH   = 4;
	localparam int CTRL_NE      = 6;
	localparam int CTRL_NF      = 7;
	localparam int IRQ_ERR      = 1;
	localparam int IRQ_NE       = 2;
	localparam int IRQ_NF       = 3;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [8:0]  THR_RST     = 9'h008;
	localparam logic [3:0]  IRQ_EN_RST  = 4'h0;
	localparam logic        SIZE_RST    = 1'b0;
	// ****************************************
	// Register port request
	// ****************************************
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
		logic              wr;
		logic              rd;
	} sbf_reg_req_t;
endpackage

// file: rtl/sbf_buffer.sv
// Shared byte buffer: storage FIFO and register front end
`timescale 1ns/100ps

// ****************************************
// Storage FIFO
// ****************************************
module sbf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 512,
	parameter int AW    = $clog2(DEPTH)
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset,
	// Control
	input  wire logic             flush,
	input  wire logic [AW:0]      cap,
	// Fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// Drain side
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready,
	// Status
	output logic [AW:0]           level
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic             push;
	logic             pop;

	assign in_ready  = level < cap;
	assign out_valid = level != '0;
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_ready & out_valid;

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset || flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset || flush) begin
			level <= '0;
		end else begin
			case ({push, pop})
				2'b10: begin
					level <= level + 1'b1;
				end
				2'b01: begin
					level <= level - 1'b1;
				end
				default: begin
					level <= level;
				end
			endcase
		end
	end
endmodule

module sbf_buffer #(
	parameter int DEPTH = sbf_pkg::BUF_DEPTH
) (
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 reset,
	// Register port
	input  wire sbf_pkg::sbf_reg_req_t reg_req,
	output logic [7:0]                reg_rdata,
	// State machine fill side
	input  wire logic                 sm_wr_valid,
	input  wire logic [7:0]           sm_wr_data,
	output logic                      sm_wr_ready,
	// State machine drain side
	input  wire logic                 sm_rd_req,
	output logic [7:0]                sm_rd_data,
	output logic                      sm_rd_valid,
	// Interrupt
	output logic                      irq_out
);
	import sbf_pkg::*;

	logic [CNT_W-1:0] level;
	logic [CNT_W-1:0] cap;
	logic [CNT_W-1:0] thr_ext;
	logic [CNT_W-1:0] room;
	logic [8:0]       thr;
	logic             size_limit;
	logic [3:0]       irq_en;
	logic [3:0]       irq_stat;
	logic [3:0]       next_irq_stat;
	logic [3:0]       irq_set;
	logic             near_full_flag;
	logic             near_empty_flag;
	logic             nf_now;
	logic             ne_now;
	logic             in_ready;
	logic             out_valid;
	logic [7:0]       out_data;
	logic             sm_push;
	logic             host_push;
	logic             host_pop;
	logic             flush;
	logic             ovf_event;
	logic             fifo_in_valid;
	logic [7:0]       fifo_in_data;
	logic [7:0]       next_rdata;

	// ****************************************
	// Decode and data path
	// ****************************************
	assign host_push = reg_req.wr && reg_req.addr == OFF_DATA;
	assign host_pop  = reg_req.rd && reg_req.addr == OFF_DATA;
	assign flush     = reg_req.wr && reg_req.addr == OFF_CTRL && reg_req.wdata[CTRL_FLUSH];
	assign sm_push       = sm_wr_valid & sm_wr_ready;
	assign fifo_in_valid = sm_push | host_push;
	assign fifo_in_data  = sm_push ? sm_wr_data : reg_req.wdata;
	assign ovf_event     = host_push & (sm_push | ~in_ready);
	assign cap       = size_limit ? CAP_LIMIT : CAP_FULL;
	assign thr_ext   = {1'b0, thr};
	assign room      = cap - level;
	assign nf_now    = (level >= cap) || (room <= thr_ext);
	assign ne_now    = level <= thr_ext;

	sbf_fifo #(
		.WIDTH (8),
		.DEPTH (DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.flush     (flush),
		.cap       (cap),
		.in_valid  (fifo_in_valid),
		.in_data   (fifo_in_data),
		.in_ready  (in_ready),
		.out_valid (out_valid),
		.out_data  (out_data),
		.out_ready (sm_rd_req | host_pop),
		.level     (level)
	);

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			size_limit <= SIZE_RST;
			thr        <= THR_RST;
			irq_en     <= IRQ_EN_RST;
		end else if (reg_req.wr) begin
			if (reg_req.addr == OFF_CTRL) begin
				size_limit <= reg_req.wdata[CTRL_SIZE];
				thr[8]     <= reg_req.wdata[CTRL_THR_MSB];
			end
			if (reg_req.addr == OFF_THR_LO) begin
				thr[7:0] <= reg_req.wdata;
			end
			if (reg_req.addr == OFF_IRQ_EN) begin
				irq_en <= reg_req.wdata[3:0];
			end
		end
	end

	// ****************************************
	// State machine ports
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sm_wr_ready <= 1'b0;
			sm_rd_valid <= 1'b0;
			sm_rd_data  <= 8'h00;
		end else begin
			// Keep one slot of slack for a write that lands in the same cycle
			sm_wr_ready <= (level < cap) && (room > READY_SLACK);
			sm_rd_valid <= sm_rd_req & out_valid;
			if (sm_rd_req && out_valid) begin
				sm_rd_data <= out_data;
			end
		end
	end

	// ****************************************
	// Alerts and interrupt
	// ****************************************
	// one threshold, two alerts
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			// Empty buffer sits under the reset threshold, so no false rise
			near_full_flag  <= 1'b0;
			near_empty_flag <= 1'b1;
		end else begin
			near_full_flag  <= nf_now;
			near_empty_flag <= ne_now;
		end
	end

	always_comb begin
		irq_set          = 4'h0;
		irq_set[IRQ_ERR] = ovf_event;
		irq_set[IRQ_NE]  = ne_now & ~near_empty_flag;
		irq_set[IRQ_NF]  = nf_now & ~near_full_flag;
		next_irq_stat    = irq_stat;
		if (reg_req.wr && reg_req.addr == OFF_IRQ_STAT) begin
			next_irq_stat = irq_stat & ~reg_req.wdata[3:0];
		end
		next_irq_stat = next_irq_stat | irq_set;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			irq_stat <= 4'h0;
			irq_out  <= 1'b0;
		end else begin
			irq_stat <= next_irq_stat;
			irq_out  <= |(irq_stat & irq_en);
		end
	end

	// ****************************************
	// Read back
	// ****************************************
	always_comb begin
		next_rdata = 8'h00;
		case (reg_req.addr)
			OFF_CTRL: begin
				next_rdata[CTRL_NF]       = near_full_flag;
				next_rdata[CTRL_NE]       = near_empty_flag;
				next_rdata[CTRL_SIZE]     = size_limit;
				next_rdata[CTRL_THR_MSB]  = thr[8];
				next_rdata[CTRL_FILL_HI]  = level[9];
				next_rdata[CTRL_FILL_LO]  = level[8];
			end
			OFF_THR_LO: begin
				next_rdata = thr[7:0];
			end
			OFF_FILL: begin
				next_rdata = level[7:0];
			end
			OFF_DATA: begin
				next_rdata = out_valid ? out_data : 8'h00;
			end
			OFF_IRQ_STAT: begin
				next_rdata[3:0] = irq_stat;
			end
			OFF_IRQ_EN: begin
				next_rdata[3:0] = irq_en;
			end
			default: begin
				next_rdata = 8'h00;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_req.rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	AST_FLUSH_EMPTIES: assert property (
		@(posedge sys_clk) disable iff (reset) flush |=> level == '0)
		else $error("flush did not empty buffer");
	AST_LIMIT_CAP: assert property (
		@(posedge sys_clk) disable iff (reset)
		size_limit && $stable(size_limit) && $past(level) <= CAP_LIMIT |-> level <= CAP_LIMIT)
		else $error("fill count beyond limited capacity");
	AST_COUNT_UP: assert property (
		@(posedge sys_clk) disable iff (reset)
		fifo_in_valid && in_ready && !(sm_rd_req || host_pop) && !flush
		|=> level == $past(level) + 1'b1)
		else $error("fill count did not rise");
	AST_COUNT_DOWN: assert property (
		@(posedge sys_clk) disable iff (reset)
		(sm_rd_req || host_pop) && out_valid && !fifo_in_valid && !flush
		|=> level == $past(level) - 1'b1)
		else $error("fill count did not fall");
	AST_OVF_FLAG: assert property (
		@(posedge sys_clk) disable iff (reset)
		host_push && !in_ready |=> irq_stat[IRQ_ERR])
		else $error("overflow flag not set");
	AST_DISCARD: assert property (
		@(posedge sys_clk) disable iff (reset)
		host_push && !in_ready && !sm_rd_req && !host_pop && !flush
		|=> $stable(level))
		else $error("write into full buffer changed count");
	AST_NEAR_EMPTY: assert property (
		@(posedge sys_clk) disable iff (reset)
		$past(level) <= {1'b0, $past(thr)} |-> near_empty_flag)
		else $error("near empty flag missing");
	AST_NEAR_FULL: assert property (
		@(posedge sys_clk) disable iff (reset)
		level == cap |=> near_full_flag)
		else $error("near full flag missing at full");
	AST_IRQ_NE: assert property (
		@(posedge sys_clk) disable iff (reset)
		$rose(near_empty_flag) && irq_en[IRQ_NE] && $stable(irq_en)
		&& !(reg_req.wr && reg_req.addr == OFF_IRQ_STAT) |=> irq_out)
		else $error("near empty interrupt missing");
	AST_IRQ_NF: assert property (
		@(posedge sys_clk) disable iff (reset)
		$rose(near_full_flag) && irq_en[IRQ_NF] && $stable(irq_en)
		&& !(reg_req.wr && reg_req.addr == OFF_IRQ_STAT) |=> irq_out)
		else $error("near full interrupt missing");
	AST_FLAG_READ: assert property (
		@(posedge sys_clk) disable iff (reset)
		reg_req.rd && reg_req.addr == OFF_CTRL
		|=> reg_rdata[CTRL_NF] == $past(near_full_flag) && !reg_rdata[CTRL_FLUSH])
		else $error("control read back wrong");
endmodule

// file: tb/sbf_sm_model.sv
// State machine side model for the shared byte buffer
`timescale 1ns/100ps
module sbf_sm_model (
	// Clock
	input  wire logic       sys_clk,
	// Fill side
	output logic            sm_wr_valid,
	output logic [7:0]      sm_wr_data,
	input  wire logic       sm_wr_ready,
	// Drain side
	output logic            sm_rd_req,
	input  wire logic [7:0] sm_rd_data,
	input  wire logic       sm_rd_valid
);
	logic [7:0] got_q[$];
	initial begin
		sm_wr_valid = 1'b0;
		sm_wr_data  = 8'h00;
		sm_rd_req   = 1'b0;
	end
	task automatic push(input int n, input logic [7:0] base);
		for (int i = 0; i < n; i++) begin
			sm_wr_valid <= 1'b1;
			sm_wr_data  <= base + 8'(i);
			do @(posedge sys_clk); while (sm_wr_ready !== 1'b1);
		end
		sm_wr_valid <= 1'b0;
		sm_wr_data  <= ~sm_wr_data;
	endtask
	task automatic pop(input int n);
		sm_rd_req <= 1'b1;
		repeat (n) @(posedge sys_clk);
		sm_rd_req <= 1'b0;
	endtask
	always @(posedge sys_clk) begin
		if (sm_rd_valid === 1'b1)
			got_q.push_back(sm_rd_data);
	end
endmodule

// file: tb/shared_byte_fifo_with_watermark_tb.sv
// Self-checking bench for the shared byte buffer
`timescale 1ns/100ps
module shared_byte_fifo_with_watermark_tb;
	import sbf_pkg::*;
	localparam logic [7:0] IRQ_ALL = 8'((1 << IRQ_ERR) | (1 << IRQ_NE) | (1 << IRQ_NF));
	logic          sys_clk;
	logic          reset;
	sbf_reg_req_t  req;
	logic [7:0]    reg_rdata;
	logic          sm_wr_valid;
	logic [7:0]    sm_wr_data;
	logic          sm_wr_ready;
	logic          sm_rd_req;
	logic [7:0]    sm_rd_data;
	logic          sm_rd_valid;
	logic          irq_out;
	int            err_total;
	int            n_tests;
	int            cycles;
	sbf_buffer i_sbf_buffer (.sys_clk(sys_clk), .reset(reset), .reg_req(req),
		.reg_rdata(reg_rdata), .sm_wr_valid(sm_wr_valid), .sm_wr_data(sm_wr_data),
		.sm_wr_ready(sm_wr_ready), .sm_rd_req(sm_rd_req), .sm_rd_data(sm_rd_data),
		.sm_rd_valid(sm_rd_valid), .irq_out(irq_out));
	sbf_sm_model i_sbf_sm_model (.sys_clk(sys_clk), .sm_wr_valid(sm_wr_valid),
		.sm_wr_data(sm_wr_data), .sm_wr_ready(sm_wr_ready), .sm_rd_req(sm_rd_req),
		.sm_rd_data(sm_rd_data), .sm_rd_valid(sm_rd_valid));
	// ****************************************
	// Bus and check tasks
	// ****************************************
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		req.wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		req.rd <= 1'b0;
		#1 chk({2'b00, reg_rdata}, {2'b00, e});
		@(posedge sys_clk);
	endtask
	task automatic fill(input int n, input logic [7:0] b);
		for (int i = 0; i < n; i++)
			wr(OFF_DATA, b + 8'(i));
	endtask
	function automatic logic [7:0] cv(input logic nf, ne, sz, tm, input logic [9:0] c);
		cv = 8'h00;
		cv[CTRL_NF] = nf;
		cv[CTRL_NE] = ne;
		cv[CTRL_SIZE] = sz;
		cv[CTRL_THR_MSB] = tm;
		cv[CTRL_FILL_HI] = c[9];
		cv[CTRL_FILL_LO] = c[8];
	endfunction
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		rd(OFF_CTRL, cv(0, 1, 0, 0, 0));
		rd(OFF_THR_LO, THR_RST[7:0]);
		rd(OFF_FILL, 8'h00);
		rd(OFF_IRQ_EN, 8'h00);
		rd(OFF_IRQ_STAT, 8'h00);
		rd(7'h7f, 8'h00);
	endtask
	task automatic t_order();
		fill(5, 8'ha0);
		rd(OFF_FILL, 8'h05);
		wr(OFF_FILL, 8'hff);
		rd(OFF_FILL, 8'h05);
		for (int i = 0; i < 5; i++)
			rd(OFF_DATA, 8'ha0 + 8'(i));
		rd(OFF_DATA, 8'h00);
		rd(OFF_FILL, 8'h00);
	endtask
	task automatic t_limit();
		wr(OFF_IRQ_EN, IRQ_ALL);
		wr(OFF_IRQ_STAT, IRQ_ALL);
		rd(OFF_IRQ_STAT, 8'h00);
		wr(OFF_CTRL, 8'h1 << CTRL_SIZE);
		fill(246, 8'h00);
		rd(OFF_CTRL, cv(0, 0, 1, 0, 246));
		fill(1, 8'h00);
		rd(OFF_CTRL, cv(1, 0, 1, 0, 247));
		rd(OFF_IRQ_STAT, 8'h1 << IRQ_NF);
		chk({9'h000, irq_out}, 10'h001);
		fill(9, 8'h00);
		rd(OFF_FILL, 8'hff);
		rd(OFF_IRQ_STAT, 8'((1 << IRQ_NF) | (1 << IRQ_ERR)));
		wr(OFF_CTRL, 8'((1 << CTRL_SIZE) | (1 << CTRL_FLUSH)));
		rd(OFF_FILL, 8'h00);
		rd(OFF_CTRL, cv(0, 1, 1, 0, 0));
		rd(OFF_IRQ_STAT, IRQ_ALL);
		wr(OFF_IRQ_STAT, IRQ_ALL);
		wr(OFF_IRQ_EN, 8'h00);
		chk({9'h000, irq_out}, 10'h000);
		fill(255, 8'h00);
		rd(OFF_FILL, 8'hff);
		wr(OFF_CTRL, 8'h1 << CTRL_FLUSH);
	endtask
	task automatic t_thr();
		wr(OFF_IRQ_STAT, IRQ_ALL);
		wr(OFF_IRQ_EN, 8'h1 << IRQ_NE);
		wr(OFF_CTRL, 8'h1 << CTRL_THR_MSB);
		wr(OFF_THR_LO, 8'h00);
		fill(256, 8'h00);
		rd(OFF_CTRL, cv(1, 1, 0, 1, 256));
		fill(1, 8'h00);
		rd(OFF_CTRL, cv(1, 0, 0, 1, 257));
		rd(OFF_FILL, 8'h01);
		chk({9'h000, irq_out}, 10'h000);
		wr(OFF_CTRL, 8'h1 << CTRL_FLUSH);
		wr(OFF_THR_LO, 8'h08);
		chk({9'h000, irq_out}, 10'h001);
		rd(OFF_IRQ_STAT, 8'((1 << IRQ_NE) | (1 << IRQ_NF)));
		wr(OFF_IRQ_EN, 8'h00);
	endtask
	task automatic t_shared();
		// host keeps off the data register while the model runs
		i_sbf_sm_model.push(4, 8'h30);
		rd(OFF_FILL, 8'h04);
		for (int i = 0; i < 4; i++)
			rd(OFF_DATA, 8'h30 + 8'(i));
		i_sbf_sm_model.got_q.delete();
		fill(3, 8'h50);
		i_sbf_sm_model.pop(3);
		repeat (2) @(posedge sys_clk);
		chk(10'(i_sbf_sm_model.got_q.size()), 10'd3);
		for (int i = 0; i < 3; i++)
			chk({2'b00, i_sbf_sm_model.got_q[i]}, 10'h050 + 10'(i));
		i_sbf_sm_model.got_q.delete();
		i_sbf_sm_model.push(510, 8'h00);
		rd(OFF_CTRL, cv(1, 0, 0, 0, 510));
		i_sbf_sm_model.pop(512);
		repeat (2) @(posedge sys_clk);
		chk(10'(i_sbf_sm_model.got_q.size()), 10'd510);
		rd(OFF_FILL, 8'h00);
	endtask
	// ****************************************
	// Clock, timeout and main sequence
	// ****************************************
	initial sys_clk = 1'b0;
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 30000) begin
			err_total++;
			give_verdict();
		end
	end
	initial begin
		reset = 1'b1;
		req = '0;
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		t_reset();
		t_order();
		t_limit();
		t_thr();
		t_shared();
		give_verdict();
	end
endmodule
